// ---- bsc_consts.svh ----
// Constants of the boot serial command handler: framing bytes, codes,
// lengths and reset values. Included by the design file and the testbench.
//
// Summary of operation
// R1: Wait for header byte; drop all others.
// R2: Missing terminator byte gives packet error.
// R3: Checksum mismatch gives checksum error.
// R4: Length against format or command: packet error.
// R5: After length/checksum errors, no processing; wait.
// R6: Report highest-priority error only; fill ones.
// R7: Unsupported parameter identifier gives parameter error.
// R8: Init state byte: 000b off, 111b on.
// R9: Recognise inquiry: code 0, length 1, sum ff.
// R10: Group D: unauthenticated debug identifier refuses inquiry.
// R11: Inquiry OK: 81, len 0a, codes 0, sum fe.
// R12: Inquiry failure: code 80, status, detail, address.
// R13: Signature request 3a with sum c5 answered.
// R14: Parameter query 52, two bytes; replies 52/d2.
// R15: Signature reply 3a or error ba, then wait.
// R16: Checksum makes byte sum from length zero.
// R17: Host waits for whole response before next.
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

`define BSC_CMD_HDR 8'h01
`define BSC_TERM 8'h03
`define BSC_RESP_HDR 8'h81
`define BSC_CMD_INQ 8'h00
`define BSC_CMD_SIG 8'h3a
`define BSC_CMD_PRM 8'h52
`define BSC_CODE_ERR 8'h80
`define BSC_CODE_INQ_OK 8'h00
`define BSC_LEN_INQ 16'h0001
`define BSC_LEN_SIG 16'h0001
`define BSC_LEN_PRM 16'h0002
`define BSC_LEN_FMT_MAX 16'h0401
`define BSC_RLEN_STATUS 8'h0a
`define BSC_RLEN_PARAM 8'h02
`define BSC_RLEN_SIG 8'h2a
`define BSC_PARAM_ID_INIT 8'h01
`define BSC_PVAL_ON 8'h07
`define BSC_PVAL_OFF 8'h00
`define BSC_FILL 8'hff
`define BSC_STAT_OK 8'h00
`define BSC_STAT_PKT 8'hc1
`define BSC_STAT_SUM 8'hc2
`define BSC_STAT_PARAM 8'hc3
`define BSC_STAT_ACCEPT 8'hc4
`define BSC_STAT_UNSUP 8'hc5
`define BSC_SIG_BYTES 41
`define BSC_RST_BYTE 8'h00
`define BSC_RST_LEN 16'h0000
`define BSC_RST_IDX 6'h00

`endif

// ---- bsc_pkg.sv ----
// Types of the boot serial command handler.
// Assumes the constants header supplies all numeric values.
package bsc_pkg;

  typedef enum logic [2:0]
  {
    BSC_IDLE,
    BSC_LEN_HI,
    BSC_LEN_LO,
    BSC_BODY,
    BSC_SUM,
    BSC_TERM,
    BSC_RESP
  } bsc_state_t;

  typedef enum logic [1:0]
  {
    BSC_K_STATUS,
    BSC_K_PARAM,
    BSC_K_SIG
  } bsc_kind_t;

  typedef struct packed
  {
    bsc_kind_t kind;
    logic [7:0] code;
    logic [7:0] status;
    logic [7:0] len_lo;
    logic [7:0] pval;
  } bsc_resp_t;

endpackage

// ---- bsc_handler.sv ----
// Command packet receiver and responder of the serial boot protocol.
// Assumes byte streams synchronous to clk; the host waits for each
// whole response before it sends the next command.
`timescale 1ns/10ps
`include "bsc_consts.svh"

module bsc_handler
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic init_enabled,
  input wire logic group_d_variant,
  input wire logic debug_id_set,
  input wire logic debug_id_authenticated,
  input wire logic [8*`BSC_SIG_BYTES-1:0] signature_info
);

  bsc_pkg::bsc_state_t state_r;
  bsc_pkg::bsc_resp_t resp_r, resp_nxt;
  logic [15:0] len_r, cnt_r;
  logic [7:0] acc_r, cmd_r, param_id_r;
  logic [5:0] idx_r, last_idx;
  logic [7:0] tx_acc_r, tx_data_r, tx_acc_nxt, tx_data_nxt;
  logic [7:0] sig_b [0:`BSC_SIG_BYTES-1];
  logic rx_take, tx_fire, tx_last, term_eval;

  // Signature bytes, first sent byte in the top bits
  genvar gi;
  generate
    for (gi = 0; gi < `BSC_SIG_BYTES; gi = gi + 1)
    begin : g_sig
      assign sig_b[gi] = signature_info[8*(`BSC_SIG_BYTES-1-gi) +: 8];
    end
  endgenerate

  assign rx_take = ce && rx_valid;
  assign term_eval = rx_take && (state_r == bsc_pkg::BSC_TERM);
  assign tx_valid = (state_r == bsc_pkg::BSC_RESP);
  assign tx_data = tx_data_r;
  assign tx_fire = ce && tx_valid && tx_ready;
  assign last_idx = resp_r.len_lo[5:0] + 6'h04;
  assign tx_last = (idx_r == last_idx);

  // Receive and response sequencing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= bsc_pkg::BSC_IDLE;
    else if (ce)
    begin
      case (state_r)
        bsc_pkg::BSC_IDLE:
          if (rx_valid && rx_data == `BSC_CMD_HDR)  // [R1]
            state_r <= bsc_pkg::BSC_LEN_HI;
        bsc_pkg::BSC_LEN_HI:
          if (rx_valid)
            state_r <= bsc_pkg::BSC_LEN_LO;
        bsc_pkg::BSC_LEN_LO:
          if (rx_valid)
          begin
            if ({len_r[15:8], rx_data} == `BSC_RST_LEN)
              state_r <= bsc_pkg::BSC_SUM;
            else
              state_r <= bsc_pkg::BSC_BODY;
          end
        bsc_pkg::BSC_BODY:
          if (rx_valid && (cnt_r + 16'h0001) == len_r)
            state_r <= bsc_pkg::BSC_SUM;
        bsc_pkg::BSC_SUM:
          if (rx_valid)
            state_r <= bsc_pkg::BSC_TERM;
        bsc_pkg::BSC_TERM:
          if (rx_valid)
            state_r <= bsc_pkg::BSC_RESP;
        bsc_pkg::BSC_RESP:
          if (tx_valid && tx_ready && tx_last)
            state_r <= bsc_pkg::BSC_IDLE;  // [R5] [R15]
        default:
          state_r <= bsc_pkg::BSC_IDLE;
      endcase
    end
  end

  // Packet fields and running byte sum
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      len_r <= `BSC_RST_LEN;
      cnt_r <= `BSC_RST_LEN;
      acc_r <= `BSC_RST_BYTE;
      cmd_r <= `BSC_RST_BYTE;
      param_id_r <= `BSC_RST_BYTE;
    end
    else if (rx_take)
    begin
      case (state_r)
        bsc_pkg::BSC_IDLE:
        begin
          acc_r <= `BSC_RST_BYTE;
          cmd_r <= `BSC_RST_BYTE;
          param_id_r <= `BSC_RST_BYTE;
        end
        bsc_pkg::BSC_LEN_HI:
        begin
          len_r[15:8] <= rx_data;
          acc_r <= acc_r + rx_data;  // [R16]
        end
        bsc_pkg::BSC_LEN_LO:
        begin
          len_r[7:0] <= rx_data;
          acc_r <= acc_r + rx_data;
          cnt_r <= `BSC_RST_LEN;
        end
        bsc_pkg::BSC_BODY:
        begin
          acc_r <= acc_r + rx_data;
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'h0000)
            cmd_r <= rx_data;
          if (cnt_r == 16'h0001)
            param_id_r <= rx_data;
        end
        bsc_pkg::BSC_SUM:
          acc_r <= acc_r + rx_data;  // [R3]
        default:
          acc_r <= acc_r;
      endcase
    end
  end

  // Verdict on a complete packet, highest priority first
  always_comb
  begin
    logic [15:0] need_len;
    logic known;
    need_len = `BSC_RST_LEN;
    known = 1'b1;
    case (cmd_r)
      `BSC_CMD_INQ: need_len = `BSC_LEN_INQ;
      `BSC_CMD_SIG: need_len = `BSC_LEN_SIG;
      `BSC_CMD_PRM: need_len = `BSC_LEN_PRM;
      default: known = 1'b0;
    endcase
    resp_nxt.kind = bsc_pkg::BSC_K_STATUS;
    resp_nxt.code = cmd_r | `BSC_CODE_ERR;  // [R12] [R14] [R15]
    resp_nxt.status = `BSC_STAT_OK;
    resp_nxt.len_lo = `BSC_RLEN_STATUS;
    resp_nxt.pval = `BSC_PVAL_OFF;
    if (rx_data != `BSC_TERM)
      resp_nxt.status = `BSC_STAT_PKT;  // [R2] [R6]
    else if (acc_r != `BSC_RST_BYTE)
      resp_nxt.status = `BSC_STAT_SUM;  // [R3] [R6]
    else if (len_r == `BSC_RST_LEN || len_r > `BSC_LEN_FMT_MAX)
      resp_nxt.status = `BSC_STAT_PKT;  // [R4] [R6]
    else if (!known)
      resp_nxt.status = `BSC_STAT_UNSUP;
    else if (len_r != need_len)
      resp_nxt.status = `BSC_STAT_PKT;  // [R4] [R6]
    else
    begin
      case (cmd_r)
        `BSC_CMD_INQ:
          if (group_d_variant && debug_id_set && !debug_id_authenticated)
            resp_nxt.status = `BSC_STAT_ACCEPT;  // [R10]
          else
            resp_nxt.code = `BSC_CODE_INQ_OK;  // [R9] [R11]
        `BSC_CMD_SIG:
        begin
          resp_nxt.kind = bsc_pkg::BSC_K_SIG;  // [R13] [R15]
          resp_nxt.code = `BSC_CMD_SIG;
          resp_nxt.len_lo = `BSC_RLEN_SIG;
        end
        `BSC_CMD_PRM:
          if (param_id_r != `BSC_PARAM_ID_INIT)
            resp_nxt.status = `BSC_STAT_PARAM;  // [R7]
          else
          begin
            resp_nxt.kind = bsc_pkg::BSC_K_PARAM;  // [R14]
            resp_nxt.code = `BSC_CMD_PRM;
            resp_nxt.len_lo = `BSC_RLEN_PARAM;
            resp_nxt.pval = init_enabled ? `BSC_PVAL_ON
                                         : `BSC_PVAL_OFF;  // [R8]
          end
        default:
          resp_nxt.status = `BSC_STAT_UNSUP;
      endcase
    end
  end

  // Next response byte after the one being sent
  always_comb
  begin
    logic [5:0] nidx;
    logic [5:0] pidx;
    nidx = idx_r + 6'h01;
    pidx = nidx - 6'h04;
    tx_acc_nxt = tx_acc_r;
    if (idx_r >= 6'h01 && idx_r <= resp_r.len_lo[5:0] + 6'h02)
      tx_acc_nxt = tx_acc_r + tx_data_r;
    tx_data_nxt = `BSC_FILL;  // [R6]
    if (nidx == 6'h01)
      tx_data_nxt = 8'h00;
    else if (nidx == 6'h02)
      tx_data_nxt = resp_r.len_lo;
    else if (nidx == 6'h03)
      tx_data_nxt = resp_r.code;
    else if (nidx == resp_r.len_lo[5:0] + 6'h03)
      tx_data_nxt = 8'h00 - tx_acc_nxt;  // [R16]
    else if (nidx == resp_r.len_lo[5:0] + 6'h04)
      tx_data_nxt = `BSC_TERM;
    else
    begin
      case (resp_r.kind)
        bsc_pkg::BSC_K_PARAM:
          tx_data_nxt = resp_r.pval;  // [R8]
        bsc_pkg::BSC_K_SIG:
          if (pidx < 6'd41)
            tx_data_nxt = sig_b[pidx];
        default:
          if (pidx == 6'h00)
            tx_data_nxt = resp_r.status;  // [R12]
      endcase
    end
  end

  // Response register and byte stream
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resp_r <= '0;
      idx_r <= `BSC_RST_IDX;
      tx_acc_r <= `BSC_RST_BYTE;
      tx_data_r <= `BSC_RST_BYTE;
    end
    else if (term_eval)
    begin
      resp_r <= resp_nxt;
      idx_r <= `BSC_RST_IDX;
      tx_acc_r <= `BSC_RST_BYTE;
      tx_data_r <= `BSC_RESP_HDR;  // [R11]
    end
    else if (tx_fire && !tx_last)
    begin
      idx_r <= idx_r + 6'h01;
      tx_acc_r <= tx_acc_nxt;
      tx_data_r <= tx_data_nxt;
    end
  end

  sequence s_term_seen;
    ce && rx_valid && state_r == bsc_pkg::BSC_TERM;
  endsequence
  sequence s_good_frame;
    s_term_seen ##0 (rx_data == `BSC_TERM && acc_r == 8'h00);
  endsequence

  property p_drop_other;
    @(posedge clk) disable iff (!rst_n)
    ce && rx_valid && state_r == bsc_pkg::BSC_IDLE
      && rx_data != `BSC_CMD_HDR |=> state_r == bsc_pkg::BSC_IDLE;
  endproperty
  a_drop_other: assert property (p_drop_other)  // [R1]
    else $error("non-header byte left idle");
  property p_term_err;
    @(posedge clk) disable iff (!rst_n)
    s_term_seen ##0 rx_data != `BSC_TERM |=>
      resp_r.status == `BSC_STAT_PKT && state_r == bsc_pkg::BSC_RESP;
  endproperty
  a_term_err: assert property (p_term_err)  // [R2]
    else $error("missing terminator not packet error");
  property p_sum_err;
    @(posedge clk) disable iff (!rst_n)
    s_term_seen ##0 (rx_data == `BSC_TERM && acc_r != 8'h00) |=>
      resp_r.status == `BSC_STAT_SUM;
  endproperty
  a_sum_err: assert property (p_sum_err)  // [R3]
    else $error("bad checksum not reported");
  property p_fmt_err;
    @(posedge clk) disable iff (!rst_n)
    s_good_frame ##0 len_r == 16'h0000 |=> resp_r.status == `BSC_STAT_PKT;
  endproperty
  a_fmt_err: assert property (p_fmt_err)  // [R4]
    else $error("zero length not packet error");
  property p_back_idle;
    @(posedge clk) disable iff (!rst_n)
    tx_fire && tx_last |=> state_r == bsc_pkg::BSC_IDLE && !tx_valid;
  endproperty
  a_back_idle: assert property (p_back_idle)  // [R5]
    else $error("no return to idle after response");
  property p_param_err;
    @(posedge clk) disable iff (!rst_n)
    s_good_frame ##0 (cmd_r == `BSC_CMD_PRM && len_r == 16'h0002
      && param_id_r != 8'h01) |=>
      resp_r.status == `BSC_STAT_PARAM && resp_r.code == 8'hd2;
  endproperty
  a_param_err: assert property (p_param_err)  // [R7]
    else $error("unsupported identifier not refused");
  property p_parameter_value_byte_val;
    @(posedge clk) disable iff (!rst_n)
    tx_valid && resp_r.kind == bsc_pkg::BSC_K_PARAM && idx_r == 6'h04
      |-> tx_data == 8'h00 || tx_data == 8'h07;
  endproperty
  a_parameter_value_byte_val: assert property (p_parameter_value_byte_val)  // [R8]
    else $error("parameter byte malformed");
  property p_accept_err;
    @(posedge clk) disable iff (!rst_n)
    s_good_frame ##0 (cmd_r == 8'h00 && len_r == 16'h0001
      && group_d_variant && debug_id_set && !debug_id_authenticated)
      |=> resp_r.status == `BSC_STAT_ACCEPT && resp_r.code == 8'h80;
  endproperty
  a_accept_err: assert property (p_accept_err)  // [R10]
    else $error("unauthenticated inquiry accepted");
  property p_inq_sum;
    @(posedge clk) disable iff (!rst_n)
    tx_valid && resp_r.code == 8'h00 && resp_r.status == 8'h00
      && idx_r == 6'h0d |-> tx_data == 8'hfe;
  endproperty
  a_inq_sum: assert property (p_inq_sum)  // [R11]
    else $error("inquiry ok checksum wrong");
  property p_resp_head;
    @(posedge clk) disable iff (!rst_n)
    s_term_seen |=> tx_valid && tx_data == 8'h81 && idx_r == 6'h00;
  endproperty
  a_resp_head: assert property (p_resp_head)  // [R11] [R12]
    else $error("response header missing");
endmodule

// ---- bsc_host.sv ----
// Host model: sends whole command packets, collects response bytes.
// Assumes byte streams synchronous to clk; slow stalls every other cycle.
`timescale 1ns/10ps

module bsc_host
(
  input wire logic clk,
  input wire logic slow,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  logic [7:0] got[$];
  logic stall_r = 1'b0;

  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end

  // Packet bytes back to back; caller waits for the whole reply
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = b[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask

  always @(negedge clk)
  begin
    stall_r <= ~stall_r;
    tx_ready <= slow ? stall_r : 1'b1;
  end

  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back(tx_data);
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench of the boot serial command handler.
// Assumes the host model above stands on the byte streams.
`timescale 1ns/10ps
`include "bsc_consts.svh"

module testbench;
  typedef struct packed
  {
    logic [7:0][7:0] b;
    logic [3:0] n;
    logic [3:0] cfg;
    logic [1:0] kind;
    logic [7:0] code;
    logic [7:0] val;
  } bsc_row_t;

  logic clk, rst_n, ce, rx_valid, tx_ready, tx_valid, slow;
  logic [7:0] rx_data, tx_data;
  logic init_enabled, group_d_variant, debug_id_set;
  logic debug_id_authenticated;
  logic [8*`BSC_SIG_BYTES-1:0] sig_info;
  logic [7:0] exp[$];
  int fail_count = 0;
  int cmp_count = 0;

  // Bytes left aligned; cfg = init, group d, id set, id authenticated
  bsc_row_t rows[18] = '{
    '{64'h01000100ff030000, 6, 4'h0, 0, 8'h00, 8'h00},
    '{64'h01000100ff030000, 6, 4'h6, 0, 8'h80, 8'hc4},
    '{64'h01000100ff030000, 6, 4'h7, 0, 8'h00, 8'h00},
    '{64'h01000100ff030000, 6, 4'h2, 0, 8'h00, 8'h00},
    '{64'h0100025201ab0300, 7, 4'h8, 1, 8'h52, 8'h07},
    '{64'h0100025201ab0300, 7, 4'h0, 1, 8'h52, 8'h00},
    '{64'h0100025202aa0300, 7, 4'h8, 0, 8'hd2, 8'hc3},
    '{64'h01000100ff040000, 6, 4'h0, 0, 8'h80, 8'hc1},
    '{64'h01000100fe030000, 6, 4'h0, 0, 8'h80, 8'hc2},
    '{64'h01000100fe040000, 6, 4'h0, 0, 8'h80, 8'hc1},
    '{64'h0100020000fe0300, 7, 4'h0, 0, 8'h80, 8'hc1},
    '{64'h0100020000000300, 7, 4'h0, 0, 8'h80, 8'hc2},
    '{64'h5501000100ff0300, 7, 4'h0, 0, 8'h00, 8'h00},
    '{64'h0100013ac5030000, 6, 4'h0, 2, 8'h3a, 8'h00},
    '{64'h0100013ac4030000, 6, 4'h0, 0, 8'hba, 8'hc2},
    '{64'h01000152ad030000, 6, 4'h0, 0, 8'hd2, 8'hc1},
    '{64'h0100000003000000, 5, 4'h0, 0, 8'h80, 8'hc1},
    '{64'h0100013bc4030000, 6, 4'h0, 0, 8'hbb, 8'hc5}
  };

  bsc_handler dut_u
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .init_enabled(init_enabled),
    .group_d_variant(group_d_variant),
    .debug_id_set(debug_id_set),
    .debug_id_authenticated(debug_id_authenticated),
    .signature_info(sig_info)
  );

  bsc_host host_u
  (
    .clk(clk),
    .slow(slow),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data)
  );

  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, seen, want);
    end
  endtask

  task automatic wait_got(input int n);
    int k;
    k = 0;
    while (host_u.got.size() < n && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    if (host_u.got.size() < n)
    begin
      fail_count++;
      finish_test();
    end
  endtask

  // Expected reply; sum makes length-to-sum byte total zero
  function automatic void build(input bsc_row_t r);
    logic [7:0] s;
    exp = {8'h81, 8'h00, r.kind == 1 ? 8'h02 : r.kind == 2 ? 8'h2a : 8'h0a};
    exp.push_back(r.code);
    if (r.kind == 2)
      for (int i = `BSC_SIG_BYTES - 1; i >= 0; i--)
        exp.push_back(sig_info[8*i+:8]);
    else
      exp.push_back(r.val);
    if (r.kind == 0)
      repeat (8) exp.push_back(8'hff);
    s = 8'h00;
    for (int i = 1; i < exp.size(); i++)
      s += exp[i];
    exp.push_back(-s);
    exp.push_back(8'h03);
  endfunction

  task automatic run(input bsc_row_t r);
    logic [7:0] q[$];
    {init_enabled, group_d_variant, debug_id_set,
      debug_id_authenticated} = r.cfg;
    build(r);
    host_u.got.delete();
    for (int k = 0; k < r.n; k++)
      q.push_back(r.b[7-k]);
    host_u.send(q);
    wait_got(exp.size());
    repeat (3) @(negedge clk);
    check(8'(host_u.got.size()), 8'(exp.size()));
    foreach (exp[i])
      check(host_u.got[i], exp[i]);
    check({7'h00, tx_valid}, 8'h00);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    slow = 1'b0;
    {init_enabled, group_d_variant, debug_id_set,
      debug_id_authenticated} = 4'h0;
    for (int i = 0; i < `BSC_SIG_BYTES; i++)
      sig_info[8*i+:8] = 8'(i * 7 + 3);
    repeat (4) @(negedge clk);
    check({7'h00, tx_valid}, 8'h00);
    check(tx_data, 8'h00);
    rst_n = 1'b1;
    foreach (rows[i])
      run(rows[i]);
    // Far side stalling every other cycle
    slow = 1'b1;
    run(rows[0]);
    run(rows[13]);
    slow = 1'b0;
    // Header byte with ce low must not start a packet
    ce = 1'b0;
    host_u.send({8'h01});
    ce = 1'b1;
    run(rows[0]);
    // Reset in mid-response, then a clean inquiry
    host_u.got.delete();
    host_u.send({8'h01, 8'h00, 8'h01, 8'h00, 8'hff, 8'h03});
    wait_got(3);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    check({7'h00, tx_valid}, 8'h00);
    rst_n = 1'b1;
    run(rows[0]);
    finish_test();
  end
endmodule
